// ==== hdl/hps_sequencer.sv ====
// Function
// RULE_01: Single mode: one write one packet, auto-disconnect
// RULE_02: Held, no count: drop packet per write
// RULE_03: Held link permits single or counted packets
// RULE_04: Held link ends only on close command
// RULE_05: Stored I-field persists across packets
// RULE_06: Counted packet appends writes until count
// RULE_07: Single counted packet drops packet and request
// RULE_08: Held counted packet ends, link stays
// RULE_09: First-burst size stored, applies later packets
// RULE_10: Unbounded code keeps packet until finish
// RULE_11: After finish, link held until close
// RULE_12: Held link accepts only its peer
// RULE_13: Channel claimed only at first data write
// RULE_14: Setup commands never reserve the channel
// RULE_15: Other users' writes stall while requesting
// RULE_16: Stalled users granted after request, connect drop
// RULE_17: Raw receive accepts every connection when enabled
// RULE_18: Received words delivered in arrival order
// RULE_19: Readable received byte offset, zero marks start
// RULE_20: Host buffers 8-byte aligned, at most 16MB
// RULE_21: I-field driven with request until connect
// RULE_22: Byte offset clears when incoming packet drops
// Purpose: Source sequencer and receive offset tracker
// Assumes: One clock; link pins are synchronised here
// Notes:   A data write is one 32-bit word; stalled writes hold bvalid low
//          A stalled write holds the bus, so only self-closing links suit sharing
`timescale 1ns/10ps
`default_nettype none
module hps_sequencer
   import hps_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        connect_in,
   input  wire logic        rx_request_in,
   input  wire logic        rx_packet_in,
   input  wire logic        rx_valid_in,
   input  wire logic [31:0] rx_ifield_in,
   input  wire logic [31:0] rx_data_in,
   output hps_tx_type       tx_out,
   output logic             rx_connect_out,
   output logic [31:0]      rx_word_out,
   output logic             rx_word_valid_out
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      hps_state_type st;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  aw_addr;
      logic [31:0] wdata;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [31:0] ifield;
      logic [1:0]  user;
      logic [1:0]  owner;
      logic [HPS_USERS-1:0] held;
      logic [HPS_USERS-1:0] counted;
      logic [HPS_USERS-1:0][27:0] count;
      logic [31:0] burst;
      logic [27:0] sent;
      logic        cur_held;
      logic        cur_counted;
      logic        cur_unbounded;
      logic        close_pend;
      logic        pkt_end;
      logic        rx_en;
      logic [31:0] rx_peer;
      logic [31:0] rx_ofs;
      logic        rx_conn;
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [31:0] rxd1;
      logic [31:0] rxd2;
      logic [31:0] rxi1;
      logic [31:0] rxi2;
      hps_tx_type  tx;
      logic [31:0] rx_word;
      logic        rx_word_valid;
      logic        awrdy;
      logic        wrdy;
      logic        arrdy;
      logic [1:0]  rresp;
   } hps_all_type;
   hps_all_type q_reg;
   hps_all_type q_next;
   function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
      is_ofs = (a == o);
   endfunction : is_ofs
   // Unbounded code never ends a packet by count
   function automatic logic count_done(input logic [27:0] total, input logic [27:0] limit);
      count_done = (limit != HPS_UNBOUNDED_CODE) && (total >= limit);
   endfunction : count_done
   logic [2:0]  cmd;
   logic [1:0]  cuser;
   logic        wr_go;
   logic        data_wr;
   logic        may_send;
   logic [27:0] sent_sum;
   always_comb begin
      q_next   = q_reg;
      cmd      = q_reg.wdata[2:0];
      cuser    = q_reg.wdata[HPS_CMD_USER_LSB +: 2];
      wr_go    = q_reg.aw_got && q_reg.w_got && !q_reg.bvalid;
      data_wr  = wr_go && is_ofs(q_reg.aw_addr, HPS_OFS_DATA);
      sent_sum = q_reg.sent + 28'(HPS_WORD_BYTES);
      // Owner may send when link up; others stall while channel busy
      may_send = (q_reg.st == HPS_ST_IDLE) || (q_reg.owner == q_reg.user && q_reg.st == HPS_ST_CONN); // RULE_15
      q_next.tx.data_valid = 1'b0;
      q_next.rx_word_valid = 1'b0;
      q_next.tx.burst      = 1'b0;
      if (s_axi_awvalid && q_reg.awrdy) begin
         q_next.aw_got  = 1'b1;
         q_next.aw_addr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && q_reg.wrdy) begin
         q_next.w_got = 1'b1;
         q_next.wdata = s_axi_wdata;
      end
      if (q_reg.bvalid && s_axi_bready) begin
         q_next.bvalid = 1'b0;
         q_next.aw_got = 1'b0;
         q_next.w_got  = 1'b0;
      end
      // ****************************************
      // Register writes and commands
      // ****************************************
      if (wr_go && !data_wr) begin
         q_next.bvalid = 1'b1;
         q_next.bresp  = HPS_BRESP_OKAY;
         case (q_reg.aw_addr)
            HPS_OFS_IFIELD: q_next.ifield = q_reg.wdata; // RULE_05
            HPS_OFS_COUNT:  q_next.count[q_reg.user] = q_reg.wdata[27:0];
            HPS_OFS_BURST:  q_next.burst = q_reg.wdata; // RULE_09
            HPS_OFS_RXCTL:  q_next.rx_en = q_reg.wdata[0];
            HPS_OFS_USER:   q_next.user = q_reg.wdata[1:0];
            HPS_OFS_CMD: begin
               // Setups only mark per-user flags or load the burst register, never the channel
               case (cmd) // RULE_14
                  HPS_CMD_OPEN_HELD:  q_next.held[cuser] = 1'b1;
                  HPS_CMD_BEGIN_PKT:  q_next.counted[cuser] = 1'b1; // RULE_13
                  HPS_CMD_BURST:      q_next.burst = q_reg.ifield;
                  HPS_CMD_SET_IFIELD: q_next.held[cuser] = 1'b0;
                  HPS_CMD_FINISH_PKT: begin
                     q_next.counted[cuser] = 1'b0;
                     if (q_reg.owner == cuser && q_reg.st != HPS_ST_IDLE) begin
                        q_next.tx.packet = 1'b0; // RULE_10
                     end
                  end
                  HPS_CMD_CLOSE: begin
                     q_next.held[cuser]    = 1'b0;
                     q_next.counted[cuser] = 1'b0;
                     if (q_reg.owner == cuser && q_reg.st != HPS_ST_IDLE) begin
                        q_next.close_pend = 1'b1; // RULE_04 RULE_11
                     end
                  end
                  default: q_next.bresp = HPS_BRESP_SLVERR;
               endcase
            end
            default: q_next.bresp = HPS_BRESP_SLVERR;
         endcase
      end
      // ****************************************
      // Packet end
      // ****************************************
      // One cycle late, so the last word still goes out inside the packet
      if (q_reg.pkt_end) begin
         q_next.tx.packet = 1'b0;
         q_next.pkt_end   = 1'b0;
      end
      // ****************************************
      // Data write: claim, send, end packet
      // ****************************************
      if (data_wr && may_send) begin
         if (q_reg.st == HPS_ST_IDLE) begin
            // First write claims channel; word held until connect
            q_next.st          = HPS_ST_REQ; // RULE_13
            q_next.owner       = q_reg.user;
            q_next.tx.request  = 1'b1;
            q_next.tx.ifield   = q_reg.ifield; // RULE_21
            q_next.cur_held    = q_reg.held[q_reg.user];
            q_next.sent        = 28'h000_0000;
         end else begin
            q_next.bvalid         = 1'b1;
            q_next.bresp          = HPS_BRESP_OKAY;
            q_next.tx.data        = q_reg.wdata;
            q_next.tx.data_valid  = 1'b1;
            if (!q_reg.tx.packet) begin
               // New packet on an open link
               q_next.tx.packet      = 1'b1; // RULE_03
               q_next.tx.burst       = 1'b1; // RULE_09
               q_next.cur_counted    = q_reg.counted[q_reg.user];
               q_next.cur_unbounded  = q_reg.count[q_reg.user] == HPS_UNBOUNDED_CODE;
               q_next.sent           = 28'(HPS_WORD_BYTES);
               q_next.counted[q_reg.user] = 1'b0;
               if (!q_reg.counted[q_reg.user] || count_done(28'(HPS_WORD_BYTES), q_reg.count[q_reg.user])) begin
                  q_next.pkt_end = 1'b1; // RULE_01 RULE_02
                  if (!q_reg.cur_held) begin
                     q_next.st = HPS_ST_DROP; // RULE_07
                  end
               end
            end else begin
               q_next.tx.burst = 1'b0;
               q_next.sent     = sent_sum; // RULE_06
               if (q_reg.cur_counted && !q_reg.cur_unbounded && sent_sum >= q_reg.count[q_reg.user]) begin
                  q_next.pkt_end = 1'b1; // RULE_08
                  if (!q_reg.cur_held) begin
                     q_next.st = HPS_ST_DROP; // RULE_07
                  end
               end
            end
         end
      end
      // ****************************************
      // Link sequencing
      // ****************************************
      case (q_reg.st)
         HPS_ST_REQ: begin
            if (q_reg.s2[0]) begin
               q_next.st = HPS_ST_CONN; // RULE_21
            end
         end
         HPS_ST_CONN: begin
            if (q_reg.close_pend) begin
               q_next.st = HPS_ST_DROP;
            end
         end
         HPS_ST_DROP: begin
            // Channel frees only once connect has fallen too
            q_next.tx.request = 1'b0;
            q_next.pkt_end    = 1'b0;
            q_next.tx.packet  = 1'b0;
            q_next.close_pend = 1'b0;
            if (!q_reg.tx.request && !q_reg.s2[0]) begin
               q_next.st = HPS_ST_IDLE; // RULE_16
            end
         end
         default: ;
      endcase
      // ****************************************
      // Receive side
      // ****************************************
      // Request joins connect, packet and valid in the synchroniser
      q_next.s1   = {rx_request_in, rx_valid_in, rx_packet_in, connect_in};
      q_next.s2   = q_reg.s1;
      q_next.rxd1 = rx_data_in;
      q_next.rxd2 = q_reg.rxd1;
      q_next.rxi1 = rx_ifield_in;
      q_next.rxi2 = q_reg.rxi1;
      if (q_reg.s2[2] && q_reg.s2[1] && q_reg.rx_conn) begin
         q_next.rx_word       = q_reg.rxd2; // RULE_18
         q_next.rx_word_valid = 1'b1;
         q_next.rx_ofs        = q_reg.rx_ofs + 32'(HPS_WORD_BYTES); // RULE_19
      end
      if (!q_reg.s2[1]) begin
         q_next.rx_ofs = 32'h0000_0000; // RULE_22
      end
      // ****************************************
      // Peer filter
      // ****************************************
      // Only the held link's peer gets through while that link is up
      q_next.rx_conn = q_reg.rx_en && q_reg.s2[3] && // RULE_17
         !(q_reg.cur_held && q_reg.st != HPS_ST_IDLE && q_reg.rxi2 != q_reg.rx_peer); // RULE_12
      if (wr_go && is_ofs(q_reg.aw_addr, HPS_OFS_RXPEER)) begin
         q_next.rx_peer = q_reg.wdata;
      end
      // ****************************************
      // Register reads
      // ****************************************
      if (q_reg.rvalid && s_axi_rready) begin
         q_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q_reg.arrdy) begin
         q_next.rvalid = 1'b1;
         q_next.rresp  = HPS_BRESP_OKAY;
         case (s_axi_araddr[7:0])
            HPS_OFS_IFIELD: q_next.rdata = q_reg.ifield;
            HPS_OFS_BURST:  q_next.rdata = q_reg.burst;
            HPS_OFS_STATUS: q_next.rdata = {24'h00_0000, q_reg.owner, q_reg.st,
                                            q_reg.tx.packet, q_reg.tx.request, q_reg.s2[0], q_reg.cur_held};
            HPS_OFS_RXOFS:  q_next.rdata = q_reg.rx_ofs; // RULE_19
            HPS_OFS_RXCTL:  q_next.rdata = {31'h0000_0000, q_reg.rx_en};
            HPS_OFS_USER:   q_next.rdata = {30'h0000_0000, q_reg.user};
            HPS_OFS_RXPEER: q_next.rdata = q_reg.rx_peer;
            default:        q_next.rdata = HPS_RESP_OKAY;
         endcase
      end
      // ****************************************
      // Ready flops
      // ****************************************
      // Ready mirrors the latch state one edge ahead, so it leaves a flop
      q_next.awrdy = !q_next.aw_got;
      q_next.wrdy  = !q_next.w_got;
      q_next.arrdy = !q_next.rvalid;
   end
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end
   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready     = q_reg.awrdy;
   assign s_axi_wready      = q_reg.wrdy;
   assign s_axi_bvalid      = q_reg.bvalid;
   assign s_axi_bresp       = q_reg.bresp;
   assign s_axi_arready     = q_reg.arrdy;
   assign s_axi_rvalid      = q_reg.rvalid;
   assign s_axi_rdata       = q_reg.rdata;
   assign s_axi_rresp       = q_reg.rresp;
   assign tx_out            = q_reg.tx;
   assign rx_connect_out    = q_reg.rx_conn;
   assign rx_word_out       = q_reg.rx_word;
   assign rx_word_valid_out = q_reg.rx_word_valid;
endmodule : hps_sequencer
`default_nettype wire

// ==== hdl/hps_pkg.sv ====
// Purpose: Shared constants and types for the packet sequencer
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses
package hps_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] HPS_OFS_IFIELD  = 8'h00;
   localparam logic [7:0] HPS_OFS_CMD     = 8'h04;
   localparam logic [7:0] HPS_OFS_COUNT   = 8'h08;
   localparam logic [7:0] HPS_OFS_BURST   = 8'h0c;
   localparam logic [7:0] HPS_OFS_DATA    = 8'h10;
   localparam logic [7:0] HPS_OFS_STATUS  = 8'h14;
   localparam logic [7:0] HPS_OFS_RXOFS   = 8'h18;
   localparam logic [7:0] HPS_OFS_RXCTL   = 8'h1c;
   localparam logic [7:0] HPS_OFS_USER    = 8'h20;
   localparam logic [7:0] HPS_OFS_RXPEER  = 8'h24;
   // ****************************************
   // Command codes and fields
   // ****************************************
   localparam logic [2:0] HPS_CMD_SET_IFIELD  = 3'h1;
   localparam logic [2:0] HPS_CMD_OPEN_HELD   = 3'h2;
   localparam logic [2:0] HPS_CMD_CLOSE       = 3'h3;
   localparam logic [2:0] HPS_CMD_BEGIN_PKT   = 3'h4;
   localparam logic [2:0] HPS_CMD_FINISH_PKT  = 3'h5;
   localparam logic [2:0] HPS_CMD_BURST       = 3'h6;
   localparam int         HPS_CMD_USER_LSB    = 8;
   localparam logic [27:0] HPS_UNBOUNDED_CODE = 28'hfff_ffff;
   localparam logic [24:0] HPS_MAX_WRITE_BYTES = 25'h100_0000;
   localparam logic [31:0] HPS_RESP_OKAY      = 32'h0000_0000;
   localparam logic [1:0]  HPS_BRESP_OKAY     = 2'h0;
   localparam logic [1:0]  HPS_BRESP_SLVERR   = 2'h2;
   localparam int          HPS_USERS          = 4;
   localparam logic [3:0]  HPS_WORD_BYTES     = 4'h4;
   typedef enum logic [1:0] {
      HPS_ST_IDLE = 2'b00,
      HPS_ST_REQ  = 2'b01,
      HPS_ST_CONN = 2'b10,
      HPS_ST_DROP = 2'b11
   } hps_state_type;
   typedef struct packed {
      logic        request;
      logic        packet;
      logic        burst;
      logic [31:0] ifield;
      logic [31:0] data;
      logic        data_valid;
   } hps_tx_type;
   typedef struct packed {
      logic        connect;
      logic        packet;
      logic [31:0] ifield;
      logic [31:0] data;
      logic        data_valid;
   } hps_rx_type;
endpackage : hps_pkg

// ==== dv/hps_sequencer_chk.sv ====
// Purpose: Port-level assertions for the packet sequencer
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every sequencer instance
`timescale 1ns/10ps
`default_nettype none
module hps_sequencer_chk
   import hps_pkg::*;
(
   input wire logic       mclk_in,
   input wire logic       rstn_in,
   input wire logic       connect_in,
   input wire hps_tx_type tx_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   // ****************************************
   // Source side
   // ****************************************
   pkt_needs_req_a: assert property (tx_out.packet |-> tx_out.request)
      else $error("packet without request");
   word_in_pkt_a: assert property (tx_out.data_valid |-> tx_out.packet)
      else $error("word outside packet");
   // Connect passes a two-stage synchroniser first
   word_after_conn_a: assert property (tx_out.data_valid |-> $past(connect_in, 2))
      else $error("word before connect");
   ifield_hold_a: assert property (tx_out.request && $past(tx_out.request) && !connect_in
      |-> $stable(tx_out.ifield))
      else $error("ifield moved while requesting");
   word_pulse_a: assert property (tx_out.data_valid |=> !tx_out.data_valid)
      else $error("word longer than one cycle");
   burst_first_a: assert property (tx_out.burst |-> tx_out.data_valid)
      else $error("burst flag without word");
   no_rereq_a: assert property (!tx_out.request && connect_in |=> !tx_out.request)
      else $error("request before connect dropped");
   reset_idle_a: assert property ($rose(rstn_in) |-> tx_out == '0)
      else $error("outputs busy after reset");
   cover property (tx_out.data_valid && tx_out.packet);
   cover property ($fell(tx_out.packet) && tx_out.request);
   cover property ($fell(tx_out.request));
endmodule : hps_sequencer_chk
bind hps_sequencer hps_sequencer_chk hps_sequencer_chk_inst (.mclk_in, .rstn_in, .connect_in, .tx_out);
`default_nettype wire

// ==== dv/hps_dest_model.sv ====
// Purpose: Destination endpoint answering requests with connect
// Assumes: Request is a level from the source
// Notes:   DELAY sets how slowly connect answers
`timescale 1ns/10ps
`default_nettype none
module hps_dest_model
   import hps_pkg::*;
#(
   parameter int DELAY = 3
)
(
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   input  wire hps_tx_type tx_in,
   output logic            connect_out
);
   logic [3:0] wait_reg;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wait_reg    <= 4'h0;
         connect_out <= 1'b0;
      end else if (!tx_in.request) begin
         // Connect follows request down at once
         wait_reg    <= 4'h0;
         connect_out <= 1'b0;
      end else if (wait_reg == DELAY[3:0]) begin
         connect_out <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule : hps_dest_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the packet sequencer
// Assumes: AXI4-Lite master, user 0 only
// Notes:   Answers sampled at negedge, driven after posedge
`timescale 1ns/10ps
`default_nettype none
module testbench
   import hps_pkg::*;
;
   logic        mclk_in, rstn_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, connect_in, rx_request_in, rx_packet_in, rx_valid_in;
   logic        rx_connect_out, rx_word_valid_out;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rx_ifield_in, rx_data_in;
   logic [31:0] rx_word_out, rdv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   hps_tx_type  tx_out;
   int          bad_count, tests_run;
   logic [31:0] wq[$], fq[$], rq[$];
   logic        pq[$];
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   hps_sequencer hps_sequencer_inst (.*);
   hps_dest_model #(.DELAY(3)) hps_dest_model_inst (.mclk_in, .rstn_in, .tx_in(tx_out), .connect_out(connect_in));
   always @(negedge mclk_in) begin
      if (tx_out.data_valid === 1'b1) begin
         wq.push_back(tx_out.data);
         fq.push_back(tx_out.ifield);
         pq.push_back(tx_out.packet);
      end
      if (rx_word_valid_out === 1'b1) rq.push_back(rx_word_out);
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic ah, wh, bh;
      @(posedge mclk_in);
      s_axi_awaddr  <= {24'h00_0000, a};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(negedge mclk_in);
         ah = s_axi_awvalid & s_axi_awready;
         wh = s_axi_wvalid & s_axi_wready;
         bh = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge mclk_in);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         if (bh) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 2000) begin
         bad_count++;
         conclude();
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int   n;
      logic ah, rh;
      @(posedge mclk_in);
      s_axi_araddr  <= {24'h00_0000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(negedge mclk_in);
         ah = s_axi_arvalid & s_axi_arready;
         rh = s_axi_rvalid;
         d = s_axi_rdata;
         @(posedge mclk_in);
         if (ah) s_axi_arvalid <= 1'b0;
         if (rh) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 2000) begin
         bad_count++;
         conclude();
      end
   endtask : rd
   task automatic cmd(input logic [2:0] c);
      wr(HPS_OFS_CMD, {29'h0000_0000, c});
   endtask : cmd
   // Waits on request (sel 0) or receive accept (sel 1)
   task automatic wait_lvl(input logic sel, input logic v);
      int n;
      for (n = 0; n < 500 && (sel ? rx_connect_out : tx_out.request) !== v; n++) @(negedge mclk_in);
      if (n == 500) begin
         bad_count++;
         conclude();
      end
   endtask : wait_lvl
   task automatic idle;
      repeat (8) @(negedge mclk_in);
   endtask : idle
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {rx_request_in, rx_packet_in, rx_valid_in, rstn_in} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, rx_data_in, rx_ifield_in} = '0;
      s_axi_wstrb = 4'hf;
      bad_count = 0;
      tests_run = 0;
      repeat (12) @(posedge mclk_in);
      rstn_in <= 1'b1;
      wr(HPS_OFS_IFIELD, 32'h1234_5678);
      cmd(HPS_CMD_SET_IFIELD);
      idle();
      chk(tx_out.request, 32'h0000_0000);
      wr(HPS_OFS_BURST, 32'h0000_0100);
      rd(HPS_OFS_BURST, rdv);
      chk(rdv, 32'h0000_0100);
      for (int k = 1; k < 3; k++) begin
         wr(HPS_OFS_DATA, 32'ha5a5_0000 + k);
         wait_lvl(1'b0, 1'b0);
         chk(wq[k-1], 32'ha5a5_0000 + k);
         chk(pq[k-1], 32'h0000_0001);
         chk(fq[k-1], 32'h1234_5678);
      end
      wr(8'h3c, 32'h0000_0000);
      chk(resp, HPS_BRESP_SLVERR);
      cmd(HPS_CMD_OPEN_HELD);
      wr(HPS_OFS_COUNT, 32'h0000_0008);
      chk(tx_out.request, 32'h0000_0000);
      wr(HPS_OFS_DATA, 32'h0000_0003);
      idle();
      chk({tx_out.request, tx_out.packet}, 32'h0000_0002);
      cmd(HPS_CMD_BEGIN_PKT);
      wr(HPS_OFS_DATA, 32'h0000_0004);
      idle();
      chk({tx_out.request, tx_out.packet}, 32'h0000_0003);
      wr(HPS_OFS_DATA, 32'h0000_0005);
      idle();
      chk({tx_out.request, tx_out.packet}, 32'h0000_0002);
      wr(HPS_OFS_RXCTL, 32'h0000_0001);
      rx_ifield_in  <= 32'h0000_0bad;
      rx_request_in <= 1'b1;
      idle();
      chk(rx_connect_out, 32'h0000_0000);
      wr(HPS_OFS_RXPEER, 32'h0000_0bad);
      wait_lvl(1'b1, 1'b1);
      @(posedge mclk_in);
      rx_request_in <= 1'b0;
      wr(HPS_OFS_COUNT, {4'h0, HPS_UNBOUNDED_CODE});
      cmd(HPS_CMD_BEGIN_PKT);
      for (int k = 6; k < 9; k++) wr(HPS_OFS_DATA, k);
      idle();
      chk({tx_out.request, tx_out.packet}, 32'h0000_0003);
      cmd(HPS_CMD_FINISH_PKT);
      idle();
      chk({tx_out.request, tx_out.packet}, 32'h0000_0002);
      cmd(HPS_CMD_CLOSE);
      wait_lvl(1'b0, 1'b0);
      chk(wq.size(), 32'h0000_0008);
      chk(wq[7], 32'h0000_0008);
      wr(HPS_OFS_RXCTL, 32'h0000_0001);
      rx_request_in <= 1'b1;
      wait_lvl(1'b1, 1'b1);
      @(posedge mclk_in);
      rx_packet_in <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk_in);
         rx_valid_in <= 1'b1;
         rx_data_in  <= 32'hc0de_0000 + k;
         @(posedge mclk_in);
         rx_valid_in <= 1'b0;
      end
      idle();
      rd(HPS_OFS_RXOFS, rdv);
      chk(rdv, 32'h0000_000c);
      chk(rq[0], 32'hc0de_0000);
      chk(rq[2], 32'hc0de_0002);
      rx_packet_in <= 1'b0;
      idle();
      rd(HPS_OFS_RXOFS, rdv);
      chk(rdv, 32'h0000_0000);
      conclude();
   end
endmodule : testbench
`default_nettype wire
